// ===== rtl/flash_host_pkg.sv
// Package with constants for the dual-bank flash command host controller
// Summary of operation
// - Write needs select, write low, output-enable high
// - Software issues a reset to the bank after fail bit or autoselect
// - Autoselect: two unlocks then bank plus command
// - Program: two unlocks, setup, then address/data
// - Unlock bypass: unlocks, 20h, then two-write programs
// - Bypass exit: 90h at bank, then 00h
package flash_host_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    // ==========================================
    // Command codes and unlock addresses
    localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_AUTOSEL = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_BYPASS  = 8'h20;
    localparam logic [7:0] CMD_BYP_END = 8'h00;
    localparam logic [7:0] CMD_RESET   = 8'hf0;
    localparam logic [19:0] UNL1_WORD  = 20'h00555;
    localparam logic [19:0] UNL2_WORD  = 20'h002aa;
    localparam logic [19:0] UNL1_BYTE  = 20'h00aaa;
    localparam logic [19:0] UNL2_BYTE  = 20'h00555;
    localparam logic [19:0] ID_MFR     = 20'h00000;
    localparam logic [19:0] ID_DEV_W   = 20'h00001;
    localparam logic [19:0] ID_DEV_B   = 20'h00002;
    localparam logic [7:0]  ID_PROT_W  = 8'h02;
    localparam logic [7:0]  ID_PROT_B  = 8'h04;
    // ==========================================
    // Register map and timing
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_ADDR   = 4'h1;
    localparam logic [3:0] REG_WDATA  = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_RDATA  = 4'h4;
    localparam int T_STROBE_NS = 40;
    localparam int CLK_NS      = 8;
    localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] OP_READ    = 4'h0;
    localparam logic [3:0] OP_RESET   = 4'h1;
    localparam logic [3:0] OP_PROGRAM = 4'h2;
    localparam logic [3:0] OP_AUTOSEL = 4'h3;
    localparam logic [3:0] OP_BYP_ON  = 4'h4;
    localparam logic [3:0] OP_BYP_PRG = 4'h5;
    localparam logic [3:0] OP_BYP_OFF = 4'h6;
    localparam logic [3:0] OP_ID_MFR  = 4'h7;
    localparam logic [3:0] OP_ID_DEV  = 4'h8;
    localparam logic [3:0] OP_ID_PROT = 4'h9;
endpackage

// ===== rtl/flash_cmd_host.sv
// Host controller that issues command sequences to a dual-bank flash
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic [31:0]      reg_rdata_o,
    output logic [19:0]      flash_addr_o,
    output logic [15:0]      flash_dq_o,
    output logic             flash_dq_oe_o,
    input  wire logic [15:0] flash_dq_i,
    output logic             flash_ce_n_o,
    output logic             flash_oe_n_o,
    output logic             flash_we_n_o,
    output logic             flash_byte_n_o,
    input  wire logic        ready_busy_flag_i
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_NEXT, S_WAIT} state_t;

    state_t      state_r, state_nxt;
    logic [3:0]  op_r, op_nxt;
    logic [2:0]  step_r, step_nxt, nsteps;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [19:0] addr_r, addr_nxt;
    logic [15:0] wdata_r, wdata_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic        byte_mode_r, byte_mode_nxt;
    logic        fail_r, fail_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic [1:0]  rb_sync_r;
    logic [15:0] dq_s1_r, dq_s2_r;
    logic [19:0] cyc_addr;
    logic [15:0] cyc_data;
    logic        cyc_read;
    logic [19:0] bank_base;
    logic [19:0] u1, u2;

    // ==========================================
    // Pin synchronisers
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rb_sync_r <= 2'h0;
            dq_s1_r   <= 16'h0000;
            dq_s2_r   <= 16'h0000;
        end else begin
            rb_sync_r <= {rb_sync_r[0], ready_busy_flag_i};
            dq_s1_r   <= flash_dq_i;
            dq_s2_r   <= dq_s1_r;
        end
    end

    // ==========================================
    // Sequence table
    always_comb begin
        u1        = byte_mode_r ? flash_host_pkg::UNL1_BYTE : flash_host_pkg::UNL1_WORD;
        u2        = byte_mode_r ? flash_host_pkg::UNL2_BYTE : flash_host_pkg::UNL2_WORD;
        bank_base = {addr_r[19:16], 16'h0000};
        cyc_addr  = addr_r;
        cyc_data  = wdata_r;
        cyc_read  = 1'b0;
        nsteps    = 3'h1;
        case (op_r)
            flash_host_pkg::OP_RESET: begin
                cyc_data = {8'h00, flash_host_pkg::CMD_RESET};
            end
            flash_host_pkg::OP_PROGRAM: begin
                nsteps = 3'h4;
                case (step_r)
                    3'h0: begin cyc_addr = u1; cyc_data = {8'h00, flash_host_pkg::CMD_UNLOCK1}; end
                    3'h1: begin cyc_addr = u2; cyc_data = {8'h00, flash_host_pkg::CMD_UNLOCK2}; end
                    3'h2: begin cyc_addr = u1; cyc_data = {8'h00, flash_host_pkg::CMD_PROGRAM}; end
                    default: ;
                endcase
            end
            flash_host_pkg::OP_AUTOSEL, flash_host_pkg::OP_BYP_ON: begin
                nsteps = 3'h3;
                case (step_r)
                    3'h0: begin cyc_addr = u1; cyc_data = {8'h00, flash_host_pkg::CMD_UNLOCK1}; end
                    3'h1: begin cyc_addr = u2; cyc_data = {8'h00, flash_host_pkg::CMD_UNLOCK2}; end
                    default: begin
                        cyc_addr = bank_base | u1;
                        cyc_data = {8'h00, (op_r == flash_host_pkg::OP_AUTOSEL) ?
                                    flash_host_pkg::CMD_AUTOSEL : flash_host_pkg::CMD_BYPASS};
                    end
                endcase
            end
            flash_host_pkg::OP_BYP_PRG: begin
                nsteps = 3'h2;
                if (step_r == 3'h0) begin
                    cyc_data = {8'h00, flash_host_pkg::CMD_PROGRAM};
                end
            end
            flash_host_pkg::OP_BYP_OFF: begin
                nsteps = 3'h2;
                if (step_r == 3'h0) begin
                    cyc_addr = bank_base;
                    cyc_data = {8'h00, flash_host_pkg::CMD_AUTOSEL};
                end else begin
                    cyc_data = {8'h00, flash_host_pkg::CMD_BYP_END};
                end
            end
            flash_host_pkg::OP_ID_MFR: begin
                cyc_read = 1'b1;
                cyc_addr = bank_base | flash_host_pkg::ID_MFR;
            end
            flash_host_pkg::OP_ID_DEV: begin
                cyc_read = 1'b1;
                cyc_addr = bank_base | (byte_mode_r ? flash_host_pkg::ID_DEV_B : flash_host_pkg::ID_DEV_W);
            end
            flash_host_pkg::OP_ID_PROT: begin
                cyc_read = 1'b1;
                cyc_addr = {addr_r[19:8], byte_mode_r ? flash_host_pkg::ID_PROT_B : flash_host_pkg::ID_PROT_W};
            end
            default: cyc_read = 1'b1; // Plain array read, also of the idle bank
        endcase
    end

    // ==========================================
    // Bus cycle engine and register port
    always_comb begin
        state_nxt     = state_r;
        op_nxt        = op_r;
        step_nxt      = step_r;
        cnt_nxt       = cnt_r;
        addr_nxt      = addr_r;
        wdata_nxt     = wdata_r;
        rdata_nxt     = rdata_r;
        byte_mode_nxt = byte_mode_r;
        fail_nxt      = fail_r;
        rd_nxt        = 32'h0000_0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                flash_host_pkg::REG_ADDR:   rd_nxt = {12'h000, addr_r};
                flash_host_pkg::REG_WDATA:  rd_nxt = {16'h0000, wdata_r};
                flash_host_pkg::REG_STATUS: rd_nxt = {28'h0000000, fail_r, rb_sync_r[1],
                                                      byte_mode_r, state_r != S_IDLE};
                flash_host_pkg::REG_RDATA:  rd_nxt = {16'h0000, rdata_r};
                default:                    rd_nxt = 32'h0000_0000;
            endcase
        end
        case (state_r)
            S_IDLE: begin
                if (reg_wr_i) begin
                    case (reg_addr_i)
                        flash_host_pkg::REG_ADDR:  addr_nxt = reg_wdata_i[19:0];
                        flash_host_pkg::REG_WDATA: wdata_nxt = reg_wdata_i[15:0];
                        flash_host_pkg::REG_CTRL: begin
                            op_nxt        = reg_wdata_i[3:0];
                            byte_mode_nxt = reg_wdata_i[4];
                            step_nxt      = 3'h0;
                            fail_nxt      = 1'b0;
                            state_nxt     = S_SETUP;
                        end
                        default: ;
                    endcase
                end
            end
            S_SETUP: begin
                cnt_nxt   = 4'(flash_host_pkg::STROBE_CYC);
                state_nxt = S_STROBE;
            end
            S_STROBE: begin
                if (cnt_r == 4'h0) begin
                    if (cyc_read) begin
                        rdata_nxt = dq_s2_r;
                    end
                    state_nxt = S_HOLD;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            S_HOLD: state_nxt = S_NEXT;
            S_NEXT: begin
                if (step_r + 3'h1 < nsteps) begin
                    step_nxt  = step_r + 3'h1;
                    state_nxt = S_SETUP;
                end else if (op_r == flash_host_pkg::OP_PROGRAM || op_r == flash_host_pkg::OP_BYP_PRG) begin
                    state_nxt = S_WAIT; // Commands are ignored while busy, so wait
                end else begin
                    state_nxt = S_IDLE;
                end
            end
            S_WAIT: begin
                if (dq_s2_r[5] && !rb_sync_r[1]) begin
                    fail_nxt = 1'b1; // Software must then issue a reset
                end
                if (rb_sync_r[1]) begin
                    state_nxt = S_IDLE; // Bank back in array read
                end
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r     <= S_IDLE;
            op_r        <= flash_host_pkg::OP_READ;
            step_r      <= 3'h0;
            cnt_r       <= 4'h0;
            addr_r      <= 20'h00000;
            wdata_r     <= 16'h0000;
            rdata_r     <= 16'h0000;
            byte_mode_r <= 1'b0;
            fail_r      <= 1'b0;
            rd_r        <= 32'h0000_0000;
        end else begin
            state_r     <= state_nxt;
            op_r        <= op_nxt;
            step_r      <= step_nxt;
            cnt_r       <= cnt_nxt;
            addr_r      <= addr_nxt;
            wdata_r     <= wdata_nxt;
            rdata_r     <= rdata_nxt;
            byte_mode_r <= byte_mode_nxt;
            fail_r      <= fail_nxt;
            rd_r        <= rd_nxt;
        end
    end

    // ==========================================
    // Pin drive: CE and WE fall together, data held past WE rise
    logic active;
    assign active         = (state_r == S_STROBE) || (state_r == S_HOLD);
    assign reg_rdata_o    = rd_r;
    assign flash_addr_o   = cyc_addr;
    assign flash_dq_o     = cyc_data;
    assign flash_dq_oe_o  = !cyc_read && (state_r == S_SETUP || active);
    assign flash_ce_n_o   = !active;
    assign flash_oe_n_o   = !(cyc_read && state_r == S_STROBE); // OE high in writes
    assign flash_we_n_o   = !(!cyc_read && state_r == S_STROBE);
    assign flash_byte_n_o = !byte_mode_r;
endmodule
`default_nettype wire

// ===== test/flash_host_checker.sv
// Pin protocol checker for the flash command host controller
`timescale 1ns/1ns
`default_nettype none
module flash_host_checker (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic [3:0]  reg_addr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [19:0] flash_addr_o,
    input wire logic [15:0] flash_dq_o,
    input wire logic        flash_dq_oe_o,
    input wire logic        flash_ce_n_o,
    input wire logic        flash_oe_n_o,
    input wire logic        flash_we_n_o
);
    // ==========================================
    // Strobes and bus
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    strobe_excl_a: assert property (flash_we_n_o || flash_oe_n_o)
        else $error("Write and read strobes overlap");
    write_select_a: assert property (!flash_we_n_o |-> !flash_ce_n_o)
        else $error("Write strobe without chip select");
    write_drive_a: assert property (!flash_we_n_o |-> flash_dq_oe_o)
        else $error("Data not driven during write");
    read_float_a: assert property (!flash_oe_n_o |-> !flash_dq_oe_o)
        else $error("Data driven during read");
    latch_stable_a: assert property (!flash_we_n_o && $past(!flash_we_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o))
        else $error("Address or data moved inside write strobe");
    write_width_a: assert property ($fell(flash_we_n_o) |-> !flash_we_n_o [*6] ##1 flash_we_n_o)
        else $error("Write strobe not six cycles");
    read_width_a: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o [*6] ##1 flash_oe_n_o)
        else $error("Read strobe not six cycles");
    select_hold_a: assert property ($rose(flash_we_n_o) && !$past(rst_i) |-> !flash_ce_n_o)
        else $error("Chip select released with write strobe");
    busy_shown_a: assert property (reg_rd_i && reg_addr_i == flash_host_pkg::REG_STATUS && !flash_ce_n_o |=> reg_rdata_o[0])
        else $error("Busy not reported mid bus cycle");
    rdata_quiet_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("Read data outside read slot");
    cover property ($fell(flash_we_n_o));
    cover property ($fell(flash_oe_n_o));
    cover property (reg_rd_i ##1 reg_rdata_o[0]);
endmodule
bind flash_cmd_host flash_host_checker u_chk (.core_clk_i, .rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o,
    .flash_addr_o, .flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o);
`default_nettype wire

// ===== test/flash_dev_model.sv
// Behavioural dual-bank flash device seen by the host controller
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
    parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h3c, // Arbitrary value
    parameter int         PROG_NS  = 400
) (
    input  wire logic [19:0] addr_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    output logic      [15:0] dq_o,
    output logic             ready_busy_flag_o
);
    logic [15:0] mem [int];
    logic [19:0] la;
    logic [2:0]  st;
    logic        lockout;
    int          nwr;
    wire         wr = !ce_n_i && !we_n_i && oe_n_i;
    function automatic logic [15:0] rd(input logic [19:0] a);
        return mem.exists(a) ? mem[a] : 16'hffff;
    endfunction
    function automatic logic [15:0] id(input logic [19:0] a);
        case (a[7:0])
            8'h00: return {8'h00, MFR_CODE};
            8'h01: return {8'h00, DEV_CODE};
            8'h02: return {15'h0, a[15]}; // Sectors with address bit 15 set are protected
            default: return rd(a);
        endcase
    endfunction
    initial begin
        st = 3'h0;
        nwr = 0;
        lockout = 1'b0;
        ready_busy_flag_o = 1'b1;
    end
    always @(posedge wr) la = addr_i;
    // Writes during an embedded program are dropped
    // Under supply lockout every write is refused and the array reads again
    always @(negedge wr) if (lockout) st = 3'h0;
    else if (ready_busy_flag_o) begin
        nwr++;
        // Program data of F0 is data, not a reset, once the set-up is taken
        if (dq_i[7:0] == 8'hf0 && st != 3'h3 && st < 3'h5) st = 3'h0;
        else case (st)
            3'h0: st = (la[11:0] == 12'h555 && dq_i[7:0] == 8'haa) ? 3'h1 : 3'h0;
            3'h1: st = (la[11:0] == 12'h2aa && dq_i[7:0] == 8'h55) ? 3'h2 : 3'h0;
            3'h2: st = dq_i[7:0] == 8'ha0 ? 3'h3 : dq_i[7:0] == 8'h90 ? 3'h4 : dq_i[7:0] == 8'h20 ? 3'h5 : 3'h0;
            3'h3, 3'h6: begin
                mem[la] = rd(la) & dq_i;
                ready_busy_flag_o = 1'b0;
                ready_busy_flag_o <= #(PROG_NS) 1'b1;
                st = st == 3'h6 ? 3'h5 : 3'h0;
            end
            3'h5: st = dq_i[7:0] == 8'ha0 ? 3'h6 : dq_i[7:0] == 8'h90 ? 3'h7 : 3'h5;
            3'h7: st = dq_i[7:0] == 8'h00 ? 3'h0 : 3'h5;
            default: ;
        endcase
    end
    // Released bus shows the inverse so a stale sample cannot pass
    // No erase here, so no bank is ever suspended and every sector reads
    always @* dq_o = (!ce_n_i && !oe_n_i) ? (st == 3'h4 ? id(addr_i) : rd(addr_i)) : ~rd(addr_i);
endmodule
`default_nettype wire

// ===== test/flash_cmd_host_tb.sv
// Self-checking bench for the flash command host controller
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_host_tb;
    logic        core_clk_i, rst_i, reg_wr_i, reg_rd_i, dq_oe, ce_n, oe_n, we_n, byte_n, rb;
    logic [3:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, rdv;
    logic [19:0] fa, a;
    logic [15:0] fdq, dq_in, d, d2;
    int          num_errors, tests_run, n0, nw0;
    flash_cmd_host dut (.core_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .flash_addr_o(fa), .flash_dq_o(fdq), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_in), .flash_ce_n_o(ce_n),
        .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_byte_n_o(byte_n), .ready_busy_flag_i(rb));
    flash_dev_model part (.addr_i(fa), .dq_i(fdq), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .dq_o(dq_in), .ready_busy_flag_o(rb));
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    // ==========================================
    // Bus tasks and checks
    function automatic logic [15:0] exp_prog(input logic [15:0] x, y);
        return 16'hffff & x & y;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] ad, input logic [31:0] v);
        reg_addr_i <= ad;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i) reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [3:0] ad);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i) reg_rd_i <= 1'b0;
        // Read data stand only in the cycle after the strobe, so take them mid-cycle
        @(negedge core_clk_i) rdv = reg_rdata_o;
        @(posedge core_clk_i);
    endtask
    task automatic op(input logic [3:0] code, input logic [19:0] ad, input logic [15:0] dv);
        wr(flash_host_pkg::REG_ADDR, {12'h0, ad});
        wr(flash_host_pkg::REG_WDATA, {16'h0, dv});
        wr(flash_host_pkg::REG_CTRL, {28'h0, code});
        n0 = 0;
        do begin
            rd(flash_host_pkg::REG_STATUS);
            n0++;
        end while (rdv[0] !== 1'b0 && n0 < 500);
        chk("op_done", n0 < 500, 1);
        rd(flash_host_pkg::REG_RDATA);
    endtask
    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    initial begin
        #400000;
        num_errors++;
        print_verdict();
    end
    initial begin
        n0 = $urandom(32'h9842);
        {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, num_errors, tests_run} = {1'b1, 38'h0, 64'h0};
        repeat (8) @(posedge core_clk_i);
        chk("ce_in_reset", ce_n, 1);
        rst_i <= 1'b0;
        @(posedge core_clk_i);
        wr(4'hf, 32'h3);
        rd(flash_host_pkg::REG_STATUS);
        chk("idle_busy", rdv[0], 0);
        wr(flash_host_pkg::REG_CTRL, {27'h0, 1'b1, flash_host_pkg::OP_RESET});
        chk("byte_pin", byte_n, 0);
        repeat (12) @(posedge core_clk_i);
        for (int i = 0; i < 6; i++) begin
            {a, d, d2} = 52'({$urandom, $urandom});
            nw0 = part.nwr;
            if (i[0]) begin
                op(flash_host_pkg::OP_BYP_ON, a, 16'h0);
                op(flash_host_pkg::OP_BYP_PRG, a, d);
                op(flash_host_pkg::OP_BYP_PRG, a, d2);
                op(flash_host_pkg::OP_BYP_OFF, a, 16'h0);
                chk("bypass_cycles", part.nwr - nw0, 9);
            end else begin
                op(flash_host_pkg::OP_PROGRAM, a, d);
                op(flash_host_pkg::OP_PROGRAM, a, d2);
                chk("prog_cycles", part.nwr - nw0, 8);
            end
            op(flash_host_pkg::OP_READ, a, 16'h0);
            chk("read_back", rdv[15:0], exp_prog(d, d2));
        end
        chk("word_pin", byte_n, 1);
        op(flash_host_pkg::OP_AUTOSEL, 20'h10000, 16'h0);
        op(flash_host_pkg::OP_ID_MFR, 20'h10000, 16'h0);
        chk("mfr_code", rdv[7:0], part.MFR_CODE);
        op(flash_host_pkg::OP_ID_DEV, 20'h10000, 16'h0);
        chk("dev_code", rdv[7:0], part.DEV_CODE);
        op(flash_host_pkg::OP_ID_PROT, 20'h18000, 16'h0);
        chk("prot_set", rdv[7:0], 8'h01);
        op(flash_host_pkg::OP_ID_PROT, 20'h14000, 16'h0);
        chk("prot_clear", rdv[7:0], 8'h00);
        op(flash_host_pkg::OP_RESET, 20'h0, 16'h0);
        op(flash_host_pkg::OP_READ, a, 16'h0);
        chk("after_reset", rdv[15:0], exp_prog(d, d2));
        part.lockout <= 1'b1;
        op(flash_host_pkg::OP_PROGRAM, 20'h0f0f0, 16'h0000);
        part.lockout <= 1'b0;
        op(flash_host_pkg::OP_READ, 20'h0f0f0, 16'h0);
        chk("lockout_read", rdv[15:0], 16'hffff);
        print_verdict();
    end
endmodule
`default_nettype wire
